// ### core/clkgen_pkg.sv
package clkgen_pkg;

    // ====================================================================
    // timing
    localparam int SYS_CLK_PERIOD_NS = 4;             // 250 MHz system clock
    localparam int REF_MAX_PERIOD_NS = 100;           // 10 MHz validity threshold
    localparam logic [7:0] REF_TIMEOUT_CYC = 8'(REF_MAX_PERIOD_NS / SYS_CLK_PERIOD_NS);

    // ====================================================================
    // serial address and command coding
    localparam logic [4:0] ADDR_FIXED     = 5'h1b;    // upper address bits 11011
    localparam int         CMD_ACCESS_BIT = 7;        // command_access_flag position
    localparam logic [3:0] BYTE_BITS      = 4'h8;

    // register byte offsets (command codes 80h, 81h, 82h)
    localparam logic [7:0] CMD_MULT_EN    = 8'h80;
    localparam logic [7:0] CMD_TEST_CTRL  = 8'h81;
    localparam logic [7:0] CMD_REV_VENDOR = 8'h82;
    localparam logic [6:0] OFF_MULT_EN    = CMD_MULT_EN[6:0];
    localparam logic [6:0] OFF_TEST_CTRL  = CMD_TEST_CTRL[6:0];
    localparam logic [6:0] OFF_REV_VENDOR = CMD_REV_VENDOR[6:0];

    // ====================================================================
    // register fields and reset values
    localparam int         FSEL_LSB        = 4;
    localparam int         FSEL_MSB        = 6;
    localparam int         ENA_MSB         = 3;       // bit 3 enables output 0
    localparam int         TEST_BIT        = 0;
    localparam logic [7:0] MULT_EN_RESET   = 8'h1f;
    localparam logic [7:0] TEST_CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED   = 8'h00;

    // multiplier code to factor numerator / denominator
    localparam logic [3:0] FACTOR_NUM [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hf, 4'hf};
    localparam logic [2:0] FACTOR_DEN [8] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4};

    // ====================================================================
    // types
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_ADDR   = 3'b001,
        S_CMD    = 3'b010,
        S_WDATA  = 3'b011,
        S_ACK    = 3'b100,
        S_RDATA  = 3'b101,
        S_RACK   = 3'b110,
        S_IGNORE = 3'b111
    } serial_state_t;

    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] clk_true;
        logic [3:0] clk_comp;
    } clock_pins_t;

    typedef struct packed {
        logic          scl_s1, scl_s2, scl_s3;
        logic          sda_s1, sda_s2, sda_s3;
        logic          ref_s1, ref_s2, ref_s3;
        logic          en_s1, en_s2;
        logic          byp_s1, byp_s2;
        logic          pll_s1, pll_s2;
        logic [1:0]    id_s1, id_s2;
        logic [7:0]    ref_cnt;
        logic          ref_valid;
        serial_state_t fsm;
        serial_state_t after;
        logic [3:0]    cnt;
        logic [7:0]    shreg;
        logic [6:0]    ptr;
        logic          sda_oe;
        logic [7:0]    mult_en;
        logic [7:0]    test_ctrl;
        clock_pins_t   pins;
        logic          pll_pd;
        logic [3:0]    fnum;
        logic [2:0]    fden;
    } core_state_t;

endpackage : clkgen_pkg

// ### core/clock_gen_serial_config.sv
`timescale 1ns/10ps
`default_nettype none
module clock_gen_serial_config #(
    parameter logic [4:0] DEVICE_REVISION = 5'h01,    // arbitrary value
    parameter logic [2:0] VENDOR_CODE     = 3'h5      // arbitrary value
) (
    input  wire logic               sys_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               reference_clock_in,
    input  wire logic               pll_clock_in,
    input  wire logic               bypass_n_in,
    input  wire logic               output_enable_in,
    input  wire logic               strap_addr_bit0_in,
    input  wire logic               strap_addr_bit1_in,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe_out,
    output clkgen_pkg::clock_pins_t clock_pins_out,
    output logic                    pll_power_down_out,
    output logic [3:0]              pll_factor_num_out,
    output logic [2:0]              pll_factor_den_out
);
    import clkgen_pkg::*;

    // ====================================================================
    // state
    core_state_t q;
    core_state_t n;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;
    logic        ref_rise;
    logic        addr_match;
    logic [7:0]  rd_byte;
    logic        src_clk;
    logic        test_mode;
    logic [2:0]  fsel;

    // edge and condition detection on synchronised pins
    // the third stage only remembers the previous settled level
    // start and stop need the clock line high on both settled samples
    // so a data change next to a clock edge is never taken as a condition
    assign scl_rise   = q.scl_s2 & ~q.scl_s3;
    assign scl_fall   = ~q.scl_s2 & q.scl_s3;
    assign start_cond = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
    assign stop_cond  = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
    assign ref_rise   = q.ref_s2 & ~q.ref_s3;
    assign addr_match = (q.shreg[7:1] == {ADDR_FIXED, q.id_s2});

    // register read mux
    // unmapped offsets read as zero instead of aliasing a register
    // the identity byte is built from parameters, so writes cannot reach it
    always_comb begin
        if (q.ptr == OFF_MULT_EN) begin
            rd_byte = q.mult_en;
        end else if (q.ptr == OFF_TEST_CTRL) begin
            rd_byte = q.test_ctrl;
        end else if (q.ptr == OFF_REV_VENDOR) begin
            rd_byte = {DEVICE_REVISION, VENDOR_CODE};
        end else begin
            rd_byte = READ_UNMAPPED;
        end
    end

    // clock source and mode selection
    assign src_clk   = q.byp_s2 ? q.pll_s2 : q.ref_s2;
    // test behaviour also needs a live reference, a lost reference wins
    // so the outputs never drive while a lost reference forces the pll off
    assign test_mode = q.en_s2 & q.test_ctrl[TEST_BIT] & q.ref_valid;
    assign fsel      = q.mult_en[FSEL_MSB:FSEL_LSB];

    // ====================================================================
    // next-state logic
    // one copy of the state is filled here and registered below
    // every field keeps its value unless a branch below changes it
    always_comb begin
        n = q;
        // pin synchronisers
        // every pin crosses two flops before any decision reads it
        // the pll source is sampled too, so its edges may be stretched
        n.scl_s1 = scl_in;
        n.scl_s2 = q.scl_s1;
        n.scl_s3 = q.scl_s2;
        n.sda_s1 = sda_in;
        n.sda_s2 = q.sda_s1;
        n.sda_s3 = q.sda_s2;
        n.ref_s1 = reference_clock_in;
        n.ref_s2 = q.ref_s1;
        n.ref_s3 = q.ref_s2;
        n.en_s1  = output_enable_in;
        n.en_s2  = q.en_s1;
        n.byp_s1 = bypass_n_in;
        n.byp_s2 = q.byp_s1;
        n.pll_s1 = pll_clock_in;
        n.pll_s2 = q.pll_s1;
        n.id_s1  = {strap_addr_bit1_in, strap_addr_bit0_in};
        n.id_s2  = q.id_s1;

        // reference activity monitor
        // counts system cycles since the last reference rising edge
        // a stopped or too slow reference runs the count to its limit
        // the counter then parks, so it never wraps back to valid
        if (ref_rise) begin
            n.ref_cnt   = 8'h00;
            n.ref_valid = 1'b1;
        end else if (q.ref_cnt != REF_TIMEOUT_CYC) begin
            n.ref_cnt = q.ref_cnt + 8'h01;
        end else begin
            n.ref_valid = 1'b0;
        end

        // serial slave
        // without a reference the slave sits idle and lets go of the data line
        // start and stop are honoured in any state, even while ignoring
        // bits are taken on the settled clock rise, acks driven after the fall
        // apart from a reference loss, the data line only moves while the clock line is low
        if (!q.ref_valid) begin
            n.fsm    = S_IDLE;
            n.sda_oe = 1'b0;
        end else if (start_cond) begin
            n.fsm    = S_ADDR;
            n.cnt    = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_cond) begin
            n.fsm    = S_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (q.fsm)
                S_ADDR, S_CMD, S_WDATA: begin
                    if (scl_rise) begin
                        n.shreg = {q.shreg[6:0], q.sda_s2};
                        n.cnt   = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == BYTE_BITS) begin
                        n.cnt = 4'h0;
                        n.fsm = S_ACK;
                        case (q.fsm)
                            S_ADDR: begin
                                if (addr_match) begin
                                    n.sda_oe = 1'b1;
                                    n.after  = q.shreg[0] ? S_RDATA : S_CMD;
                                end else begin
                                    n.fsm = S_IGNORE;
                                end
                            end
                            S_CMD: begin
                                if (q.shreg[CMD_ACCESS_BIT] && q.shreg[6:0] <= OFF_REV_VENDOR) begin
                                    n.ptr    = q.shreg[6:0];
                                    n.sda_oe = 1'b1;
                                    n.after  = S_WDATA;
                                end else begin
                                    n.fsm = S_IGNORE;
                                end
                            end
                            default: begin
                                if (q.ptr == OFF_MULT_EN) begin
                                    n.mult_en = q.shreg;
                                end else if (q.ptr == OFF_TEST_CTRL) begin
                                    n.test_ctrl = q.shreg;
                                end
                                n.ptr    = q.ptr + 7'h01;
                                n.sda_oe = 1'b1;
                                n.after  = S_WDATA;
                            end
                        endcase
                    end
                end
                // release the acknowledge at the clock fall, or load read data
                // the first read bit goes out at once so the host sees it settled
                S_ACK: begin
                    if (scl_fall) begin
                        n.fsm    = q.after;
                        n.cnt    = 4'h0;
                        n.sda_oe = 1'b0;
                        if (q.after == S_RDATA) begin
                            n.shreg  = rd_byte;
                            n.sda_oe = ~rd_byte[7];
                        end
                    end
                end
                // shift out most significant bit first, one bit per clock fall
                // after the eighth bit the line is released for the host
                S_RDATA: begin
                    if (scl_rise) begin
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.cnt == BYTE_BITS) begin
                            n.fsm    = S_RACK;
                            n.cnt    = 4'h0;
                            n.sda_oe = 1'b0;
                        end else begin
                            n.shreg  = {q.shreg[6:0], 1'b0};
                            n.sda_oe = ~q.shreg[6];
                        end
                    end
                end
                // host acknowledge asks for the next byte, no acknowledge ends it
                // the pointer steps at the rise so the next load sees it
                S_RACK: begin
                    if (scl_rise) begin
                        if (!q.sda_s2) begin
                            n.ptr   = q.ptr + 7'h01;
                            n.after = S_RDATA;
                            n.fsm   = S_ACK;
                        end else begin
                            n.fsm = S_IGNORE;
                        end
                    end
                end
                default: begin
                    n.fsm = q.fsm;
                end
            endcase
        end

        // output pins: each channel switches true and complement together
        // a disabled channel releases both lines, driven low only for tidiness
        // the enable pin and a live reference must agree, and the channel bit too outside test mode
        // the test pattern holds every line static
        for (int i = 0; i < 4; i++) begin
            if (test_mode) begin
                n.pins.oe[i]       = 1'b1;
                n.pins.clk_true[i] = 1'b0;
                n.pins.clk_comp[i] = 1'b1;
            end else if (q.en_s2 && q.mult_en[ENA_MSB - i] && q.ref_valid) begin
                n.pins.oe[i]       = 1'b1;
                n.pins.clk_true[i] = src_clk;
                n.pins.clk_comp[i] = ~src_clk;
            end else begin
                n.pins.oe[i]       = 1'b0;
                n.pins.clk_true[i] = 1'b0;
                n.pins.clk_comp[i] = 1'b0;
            end
        end

        // PLL control
        // the pll is off in bypass and whenever the reference is missing
        // the factor pair follows the select field one cycle later
        n.pll_pd = ~q.ref_valid | ~q.byp_s2;
        n.fnum   = FACTOR_NUM[fsel];
        n.fden   = FACTOR_DEN[fsel];
    end

    // ====================================================================
    // state register
    // reset forces the safe state: pll off, outputs released
    // serial line samples start at their idle high level
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q           <= '0;
            // idle bus level, so no false edge follows reset
            q.scl_s1    <= 1'b1;
            q.scl_s2    <= 1'b1;
            q.scl_s3    <= 1'b1;
            q.sda_s1    <= 1'b1;
            q.sda_s2    <= 1'b1;
            q.sda_s3    <= 1'b1;
            q.fsm       <= S_IDLE;
            q.after     <= S_IDLE;
            q.mult_en   <= MULT_EN_RESET;
            q.test_ctrl <= TEST_CTRL_RESET;
            q.pll_pd    <= 1'b1;
            q.fnum      <= FACTOR_NUM[MULT_EN_RESET[FSEL_MSB:FSEL_LSB]];
            q.fden      <= FACTOR_DEN[MULT_EN_RESET[FSEL_MSB:FSEL_LSB]];
        end else begin
            q <= n;
        end
    end

    // outputs straight from state
    // the data line is open drain: only its enable ever changes
    assign sda_out            = 1'b0;
    assign sda_oe_out         = q.sda_oe;
    assign clock_pins_out     = q.pins;
    assign pll_power_down_out = q.pll_pd;
    assign pll_factor_num_out = q.fnum;
    assign pll_factor_den_out = q.fden;

endmodule : clock_gen_serial_config
`default_nettype wire

// ### tb/smbus_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model #(
    parameter int HALF = 50
) (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output var logic  scl_out,
    output var logic  sda_low_out
);
    // ====================================================================
    // bus idle: both lines released
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick

    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_low_out = 1'b0;
        tick(HALF / 2);
        scl_out = 1'b1;
        tick(HALF);
        sda_low_out = 1'b1;
        tick(HALF);
        scl_out = 1'b0;
        tick(HALF / 2);
    endtask : start

    // stop: data rises while the clock is high
    task automatic stop();
        sda_low_out = 1'b1;
        tick(HALF / 2);
        scl_out = 1'b1;
        tick(HALF);
        sda_low_out = 1'b0;
        tick(HALF);
    endtask : stop

    // one bit: data set in the low phase, sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low_out = ~b;
        tick(HALF / 2);
        scl_out = 1'b1;
        tick(HALF);
        r = sda_in;
        scl_out = 1'b0;
        tick(HALF / 2);
    endtask : bit_io

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;  // low level acknowledges
    endtask : wr_byte

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);  // acknowledge all but the last byte
    endtask : rd_byte
endmodule : smbus_host_model
`default_nettype wire

// ### tb/clock_gen_serial_config_chk.sv
`timescale 1ns/10ps
`default_nettype none
module clock_gen_serial_config_chk (
    input wire logic                    sys_clk_in,
    input wire logic                    rst_n_in,
    input wire logic                    reference_clock_in,
    input wire logic                    bypass_n_in,
    input wire logic                    output_enable_in,
    input wire logic                    scl_in,
    input wire logic                    sda_out,
    input wire logic                    sda_oe_out,
    input wire clkgen_pkg::clock_pins_t clock_pins_out,
    input wire logic                    pll_power_down_out,
    input wire logic [3:0]              pll_factor_num_out,
    input wire logic [2:0]              pll_factor_den_out
);
    import clkgen_pkg::*;
    // ====================================================================
    // cycles since the reference pin last changed
    logic       ref_q;
    logic [5:0] quiet;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ref_q <= 1'b0;
            quiet <= 6'h00;
        end else begin
            ref_q <= reference_clock_in;
            quiet <= (ref_q != reference_clock_in) ? 6'h00 : quiet + {5'h00, ~&quiet};
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // ====================================================================
    // output and serial checks
    AST_BYPASS_PLL_OFF: assert property (!bypass_n_in [*4] |-> pll_power_down_out)
        else $error("pll powered while bypassed");
    AST_EN_LOW_OFF: assert property (!output_enable_in [*4] |-> clock_pins_out.oe == 4'h0)
        else $error("output driven with enable pin low");
    AST_EN_GATES_OE: assert property (|clock_pins_out.oe |-> $past(output_enable_in, 2)
        || $past(output_enable_in, 3) || $past(output_enable_in, 4)) else $error("output on without enable pin");
    AST_REF_LOST_OFF: assert property (quiet >= 6'h28 |-> clock_pins_out.oe == 4'h0 && pll_power_down_out)
        else $error("outputs alive without reference");
    AST_RESET_OFF: assert property (disable iff (1'b0) !rst_n_in [*2] |->
        pll_power_down_out && clock_pins_out.oe == 4'h0 && !sda_oe_out) else $error("active in reset");
    AST_PAIR_COMP: assert property ((clock_pins_out.clk_comp & clock_pins_out.oe) ==
        (~clock_pins_out.clk_true & clock_pins_out.oe)) else $error("complement line mismatch");
    AST_SDA_OPEN_DRAIN: assert property (sda_oe_out |-> sda_out == 1'b0)
        else $error("data line driven high");
    AST_SDA_SCL_LOW: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data line moved while clock high");
    AST_FACTOR_TABLE: assert property ({pll_factor_num_out, pll_factor_den_out} inside
        {7'h19, 7'h21, 7'h29, 7'h31, 7'h41, 7'h4a, 7'h7a, 7'h7c}) else $error("factor outside table");

    C_ACK: cover property ($rose(sda_oe_out));
    C_ALL_ON: cover property (clock_pins_out.oe == 4'hf);
    C_REF_LOST: cover property (quiet >= 6'h28);
endmodule : clock_gen_serial_config_chk

bind clock_gen_serial_config clock_gen_serial_config_chk i_clock_gen_serial_config_chk (.sys_clk_in, .rst_n_in,
    .reference_clock_in, .bypass_n_in, .output_enable_in, .scl_in, .sda_out, .sda_oe_out, .clock_pins_out,
    .pll_power_down_out, .pll_factor_num_out, .pll_factor_den_out);
`default_nettype wire

// ### tb/clock_gen_serial_config_bench.sv
`timescale 1ns/10ps
`default_nettype none
module clock_gen_serial_config_bench;
    import clkgen_pkg::*;
    // ====================================================================
    // fixtures and signals
    localparam logic [4:0] REV = 5'h0a;  // arbitrary value
    localparam logic [2:0] VID = 3'h3;   // arbitrary value
    localparam logic [6:0] DEV = {ADDR_FIXED, 2'b10};
    localparam logic [7:0] RV  = {REV, VID};
    localparam logic [7:0] FTAB [8] = '{8'h19, 8'h21, 8'h29, 8'h31, 8'h41, 8'h4a, 8'h7a, 8'h7c};
    logic        sys_clk, rst_n, ref_clk, ref_run, pll_clk, byp_n, en, scl, host_low, sda_o, sda_oe, pll_pd;
    logic [3:0]  f_num;
    logic [2:0]  f_den;
    clock_pins_t pins;
    logic [31:0] lfsr = 32'hea69;
    logic [7:0]  exp_q[$], got_q[$];
    int          failures = 0, n_compared = 0;
    wire logic   sda_wire = ~(host_low | (sda_oe & ~sda_o));  // pulled up when released

    smbus_host_model #(.HALF(50)) i_smbus_host_model (.clk_in(sys_clk), .sda_in(sda_wire), .scl_out(scl),
        .sda_low_out(host_low));
    clock_gen_serial_config #(.DEVICE_REVISION(REV), .VENDOR_CODE(VID)) i_clock_gen_serial_config (
        .sys_clk_in(sys_clk), .rst_n_in(rst_n), .reference_clock_in(ref_clk), .pll_clock_in(pll_clk),
        .bypass_n_in(byp_n), .output_enable_in(en), .strap_addr_bit0_in(DEV[0]), .strap_addr_bit1_in(DEV[1]),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o), .sda_oe_out(sda_oe), .clock_pins_out(pins),
        .pll_power_down_out(pll_pd), .pll_factor_num_out(f_num), .pll_factor_den_out(f_den));

    // ====================================================================
    // clocks, random pll source, watchdog, result monitor
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        ref_clk = 1'b0;
        #5;
        forever #16 ref_clk = ref_run ? ~ref_clk : ref_clk;
    end
    always @(negedge sys_clk) begin
        lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        pll_clk <= lfsr[0];
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        failures++;
        close_out();
    end
    initial forever begin
        wait (got_q.size() > 0);
        compare(exp_q.pop_front(), got_q.pop_front());
    end

    task automatic compare(input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : compare

    task automatic expect_val(input logic [7:0] e, input logic [7:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask : expect_val

    task automatic send(input logic [7:0] d, input logic ack_exp);
        logic a;
        i_smbus_host_model.wr_byte(d, a);
        expect_val({7'h00, ack_exp}, {7'h00, a});
    endtask : send

    task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input logic two);
        i_smbus_host_model.start();
        send({DEV, 1'b0}, 1'b1);
        send(cmd, 1'b1);
        send(d[15:8], 1'b1);
        if (two) send(d[7:0], 1'b1);
        i_smbus_host_model.stop();
    endtask : wr

    task automatic rd(input logic [7:0] cmd, input logic [15:0] e, input logic two);
        logic [7:0] b;
        i_smbus_host_model.start();
        send({DEV, 1'b0}, 1'b1);
        send(cmd, 1'b1);
        i_smbus_host_model.start();
        send({DEV, 1'b1}, 1'b1);
        i_smbus_host_model.rd_byte(~two, b);
        expect_val(e[15:8], b);
        if (two) i_smbus_host_model.rd_byte(1'b1, b);
        if (two) expect_val(e[7:0], b);
        i_smbus_host_model.stop();
    endtask : rd

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // ====================================================================
    // test sequence
    initial begin
        logic [7:0] d;
        rst_n = 1'b0;
        ref_run = 1'b1;
        byp_n = 1'b1;
        en = 1'b1;
        repeat (3) @(negedge sys_clk);
        expect_val(8'h01, {7'h00, pll_pd});
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (40) @(negedge sys_clk);
        expect_val(8'h21, {1'b0, f_num, f_den});
        expect_val(8'h0f, {4'h0, pins.oe});
        rd(CMD_MULT_EN, 16'h1f00, 1'b1);
        rd(CMD_REV_VENDOR, {RV, 8'h00}, 1'b0);
        $display("reset values test done");
        for (int c = 0; c < 8; c++) begin
            wr(CMD_MULT_EN, {1'b0, 3'(c), 12'hf00}, 1'b0);
            repeat (10) @(negedge sys_clk);
            expect_val(FTAB[c], {1'b0, f_num, f_den});
        end
        $display("factor codes test done");
        d = {1'b0, lfsr[6:0]};
        wr(CMD_MULT_EN, {d, 8'h00}, 1'b1);
        rd(CMD_MULT_EN, {d, 8'h00}, 1'b1);
        expect_val({4'h0, d[0], d[1], d[2], d[3]}, {4'h0, pins.oe});
        i_smbus_host_model.start();
        send({DEV ^ 7'h01, 1'b0}, 1'b0);
        send(CMD_MULT_EN, 1'b0);
        i_smbus_host_model.start();
        send({DEV, 1'b0}, 1'b1);
        send(8'h00, 1'b0);
        i_smbus_host_model.stop();
        wr(CMD_REV_VENDOR, 16'hff00, 1'b0);
        rd(CMD_TEST_CTRL, {8'h00, RV}, 1'b1);
        rd(CMD_MULT_EN, {d, 8'h00}, 1'b0);
        $display("word and refusal test done");
        en = 1'b0;
        repeat (10) @(negedge sys_clk);
        expect_val(8'h00, {4'h0, pins.oe});
        en = 1'b1;
        byp_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        expect_val(8'h01, {7'h00, pll_pd});
        byp_n = 1'b1;
        ref_run = 1'b0;
        repeat (60) @(negedge sys_clk);
        expect_val(8'h01, {7'h00, pll_pd});
        expect_val(8'h00, {4'h0, pins.oe});
        ref_run = 1'b1;
        repeat (40) @(negedge sys_clk);
        expect_val(8'h00, {7'h00, pll_pd});
        $display("pin control test done");
        wr(CMD_MULT_EN, 16'h1000, 1'b0);
        wr(CMD_TEST_CTRL, 16'h0100, 1'b0);
        repeat (10) @(negedge sys_clk);
        expect_val(8'h0f, {4'h0, pins.oe});
        expect_val(8'h0f, {4'h0, pins.clk_comp});
        expect_val(8'h00, {4'h0, pins.clk_true});
        wr(CMD_TEST_CTRL, 16'h0000, 1'b0);
        repeat (10) @(negedge sys_clk);
        expect_val(8'h00, {4'h0, pins.oe});
        $display("test bit test done");
        repeat (10) @(negedge sys_clk);
        close_out();
    end
endmodule : clock_gen_serial_config_bench
`default_nettype wire
